// >>> verification/smpf_host_rx.sv
`timescale 1ns/1ps

// Host side of the serial link: takes bytes and splits values from footers
module smpf_host_rx (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Byte stream from device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // Pace control from bench
  input  wire logic       slow
);
  logic [7:0] got[$];
  int         nval;
  int         nfoot;
  int         err;
  logic       ended;
  logic       held;
  logic [7:0] last;

  // Slow mode refuses every other cycle so the sender must hold its byte
  always @(posedge clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      ended <= 1'b0;
      held <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      held <= tx_valid & ~tx_ready;
      last <= tx_data;
      if (held && (tx_valid !== 1'b1 || tx_data !== last)) begin
        err++;
      end
      if (tx_valid && tx_ready) begin
        got.push_back(tx_data);
        // Bit 7 and whether the previous byte ended a value tell value ends and footers apart
        if (tx_data[7]) begin
          ended <= 1'b0;
        end else if (ended) begin
          nfoot++;
          ended <= 1'b0;
        end else begin
          nval++;
          ended <= 1'b1;
        end
      end
    end
  end
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t got %h exp %h", $time, a, b); end end

module testbench;
  logic        clk = 1'b0;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        in_valid;
  logic        in_ready;
  logic [31:0] in_value;
  logic [5:0]  in_width;
  logic [1:0]  in_type;
  logic        in_pkt_last;
  logic        in_frame_last;
  logic        cfg_change;
  logic        overflow;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  tx_data;
  logic        reply_allowed;
  logic        slow;
  logic [7:0]  exp[$];
  int          fail_count;
  int          checks;
  int          cycles;

  smpf_framer #(.ADDR_W(8)) i_smpf_framer (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .in_valid(in_valid), .in_ready(in_ready),
    .in_value(in_value), .in_width(in_width), .in_type(in_type), .in_pkt_last(in_pkt_last),
    .in_frame_last(in_frame_last), .cfg_change(cfg_change), .overflow(overflow),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .reply_allowed(reply_allowed));

  smpf_host_rx i_smpf_host_rx (.clk(clk), .rst(rst), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow));

  always #25 clk = ~clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic summarize;
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; a read compares data and error response
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits for pready; the hang guard ends this wait if pready never comes
    do @(posedge clk); while (pready !== 1'b1);
    if (!w) `CHK(prdata, d)
    `CHK(pslverr, e)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Expected bytes of one value, low group first
  task automatic enc(input logic [31:0] v, input logic [5:0] w);
    int k;
    k = (int'(w) + 6) / 7;
    for (int i = 0; i < k; i++) exp.push_back({i < k - 1, 7'(v >> (7 * i))});
  endtask

  // Offers one value and holds it until taken
  task automatic send(input logic [31:0] v, input logic [5:0] w, input logic [1:0] t,
                      input logic pl, input logic fl, input logic keep);
    in_valid <= 1'b1;
    in_value <= v;
    in_width <= w;
    in_type <= t;
    in_pkt_last <= pl;
    in_frame_last <= fl;
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    @(posedge clk);
    if (keep) enc(v, w);
  endtask

  // Waits for the expected byte count, then compares the whole stream
  task automatic drain;
    for (int n = 0; n < 600 && i_smpf_host_rx.got.size() < exp.size(); n++) @(posedge clk);
    repeat (8) @(posedge clk);
    `CHK(i_smpf_host_rx.got.size(), exp.size())
    foreach (exp[i]) if (i < i_smpf_host_rx.got.size()) `CHK(i_smpf_host_rx.got[i], exp[i])
    exp.delete();
    i_smpf_host_rx.got.delete();
  endtask

  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {in_valid, in_value, in_width, in_type, in_pkt_last, in_frame_last} = 43'h0;
    {cfg_change, overflow, slow} = 3'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Register reset values and an unmapped place
    bus(1'b0, 8'h00, 32'h0, 1'b0);
    bus(1'b0, 8'h04, 32'h0, 1'b0);
    bus(1'b0, 8'h08, 32'h0, 1'b0);
    bus(1'b0, 8'h10, 32'h0, 1'b1);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h08, 32'h2, 1'b0);
    bus(1'b1, 8'h00, 32'h1, 1'b0);
    // Frame with a change event and mixed value widths
    cfg_change <= 1'b1;
    @(posedge clk);
    cfg_change <= 1'b0;
    send(32'hDEADBEEF, 6'h20, 2'h0, 1'b0, 1'b0, 1'b1);
    send(32'h0002ABCD, 6'h12, 2'h0, 1'b1, 1'b1, 1'b1);
    exp.push_back(8'h18);
    drain();
    `CHK(i_smpf_host_rx.nval, 2)
    `CHK(i_smpf_host_rx.nfoot, 1)
    `CHK(reply_allowed, 1'b1)
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h04, 32'h3, 1'b0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b0, 8'h04, 32'h0, 1'b0);
    // Multi-packet frame, every payload type, stalling receiver
    {cfg_change, overflow, slow} <= 3'h7;
    @(posedge clk);
    {cfg_change, overflow} <= 2'h0;
    for (int t = 1; t < 4; t++) begin
      send(32'h00002B3C, 6'h0E, 2'(t), 1'b1, 1'b0, 1'b1);
      exp.push_back({4'h0, 1'b1, 2'(t), 1'b1});
    end
    send(32'h0ABCDEF1, 6'h1C, 2'h0, 1'b1, 1'b1, 1'b1);
    exp.push_back(8'h19);
    drain();
    bus(1'b0, 8'h04, 32'h7, 1'b0);
    // Second measurement packet in one frame is dropped; flags were reported once
    slow <= 1'b0;
    send(32'h00001555, 6'h0E, 2'h0, 1'b1, 1'b0, 1'b1);
    exp.push_back(8'h00);
    send(32'h00000AAA, 6'h0E, 2'h0, 1'b1, 1'b1, 1'b0);
    drain();
    `CHK(reply_allowed, 1'b0)
    bus(1'b0, 8'h04, 32'hF, 1'b0);
    `CHK(i_smpf_host_rx.err, 0)
    summarize();
  end
endmodule

// >>> verilog/smpf_byte_if.sv
`timescale 1ns/1ps

// Byte stream from encoder to output stage
interface smpf_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       tail;

  modport src (output valid, output data, output tail, input ready);
  modport snk (input valid, input data, input tail, output ready);
endinterface

// >>> verilog/smpf_encoder.sv
`timescale 1ns/1ps
`include "smpf_map.svh"

module smpf_encoder (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Value load
  input  wire logic        load_valid,
  output logic             load_ready,
  input  wire logic [31:0] load_value,
  input  wire logic [5:0]  load_width,
  input  wire logic        load_tail,
  // Byte output
  smpf_byte_if.src         bo
);

  logic [31:0] sh;
  logic [2:0]  left;
  logic        tail;
  logic        busy;
  logic [5:0]  w_q;

  // Width clamp and byte count
  wire [5:0]  w_lo    = (load_width < `SMPF_MIN_WIDTH) ? `SMPF_MIN_WIDTH : load_width;
  wire [5:0]  w_cl    = (w_lo > `SMPF_MAX_WIDTH) ? `SMPF_MAX_WIDTH : w_lo;
  wire [2:0]  nbytes  = (w_cl <= `SMPF_MIN_WIDTH) ? 3'h2 :
                        (w_cl <= `SMPF_W_3BYTES)  ? 3'h3 :
                        (w_cl <= `SMPF_W_4BYTES)  ? 3'h4 : 3'h5;
  // Unused bits above the width go out as zero
  wire [31:0] vmask   = 32'hFFFFFFFF >> (`SMPF_MAX_WIDTH - w_cl);
  wire        last_by = (left == 3'h1);
  wire        take    = bo.valid & bo.ready;
  wire        load    = load_valid & load_ready;

  // Reload in the cycle the last byte leaves, so values run back to back
  assign load_ready = ~busy | (take & last_by);
  assign bo.valid   = busy;
  assign bo.data    = {~last_by, sh[6:0]};
  assign bo.tail    = tail & last_by;

  // LSB group first; right shift fills the fifth byte top with zeros
  always_ff @(posedge clk) begin
    if (rst) begin
      sh   <= 32'h0000_0000;
      left <= 3'h0;
      tail <= 1'b0;
      busy <= 1'b0;
      w_q  <= `SMPF_MIN_WIDTH;
    end else if (load) begin
      sh   <= load_value & vmask;
      left <= nbytes;
      tail <= load_tail;
      busy <= 1'b1;
      w_q  <= w_cl;
    end else if (take) begin
      sh   <= sh >> `SMPF_GRP_BITS;
      left <= left - 3'h1;
      busy <= ~last_by;
    end
  end

  // Byte count after load lies in 2..5
  byte_count_a: assert property (@(posedge clk) disable iff (rst)
    load |=> (left >= 3'h2 && left <= 3'h5))
    else $error("encoder byte count out of range");

  // Nothing above the value width survives the load
  width_zero_a: assert property (@(posedge clk) disable iff (rst)
    load |=> ((sh >> w_q) == 32'h0000_0000))
    else $error("bits above value width not zero");

  // Fifth byte keeps bits 6..4 zero
  fifth_byte_a: assert property (@(posedge clk) disable iff (rst)
    (load && nbytes == 3'h5) ##1 (take [*4]) |=> (sh[6:4] == 3'h0))
    else $error("fifth byte upper bits not zero");

endmodule

// >>> verilog/smpf_footer.sv
`timescale 1ns/1ps
`include "smpf_map.svh"

module smpf_footer (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Events
  input  wire logic              cfg_change,
  input  wire logic              overflow,
  // Frame control
  input  wire logic              capture,
  input  wire logic              frame_end,
  input  wire smpf_pkg::smpf_dtype_t dtype,
  input  wire logic              eof,
  // Footer and flag state
  output logic [7:0]             foot_byte,
  output logic                   pend_c,
  output logic                   pend_o
);

  logic frame_c;
  logic frame_o;

  // Pending flags: an event in the capture cycle waits for the next frame
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_c <= 1'b0;
      pend_o <= 1'b0;
    end else begin
      pend_c <= cfg_change | (pend_c & ~capture);
      pend_o <= overflow | (pend_o & ~capture);
    end
  end

  // Frame flags repeat in every footer of one frame, then drop
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_c <= 1'b0;
      frame_o <= 1'b0;
    end else if (capture) begin
      frame_c <= pend_c;
      frame_o <= pend_o;
    end else if (frame_end) begin
      frame_c <= 1'b0;
      frame_o <= 1'b0;
    end
  end

  // Footer byte assembly; no extra footer byte is ever sent
  always_comb begin
    foot_byte                                  = 8'h00;
    foot_byte[`SMPF_FT_EXTRA]                  = 1'b0;
    foot_byte[`SMPF_FT_PROMPT]                 = 1'b0;
    foot_byte[`SMPF_FT_EOF]                    = eof;
    foot_byte[`SMPF_FT_CHG]                    = frame_c;
    foot_byte[`SMPF_FT_DT_HI:`SMPF_FT_DT_LO]   = dtype;
    foot_byte[`SMPF_FT_OVF]                    = frame_o;
  end

  // Overflow seen before a capture shows in that frame
  ovf_carry_a: assert property (@(posedge clk) disable iff (rst)
    (capture && pend_o) |=> foot_byte[`SMPF_FT_OVF])
    else $error("overflow not carried into frame");

endmodule

// >>> verilog/smpf_framer.sv
`timescale 1ns/1ps
`include "smpf_map.svh"
// Function
// - Bit 7 flags continuation; payload in 6..0
// - Values are 2..5 bytes, LSB group first
// - Second clear bit-7 byte is the footer
// - Footer bit 6 flags an extra footer
// - Footer bit 5 always zero
// - Footer bit 4 marks last frame packet
// - Footer bit 3 reports configuration change once
// - Footer payload_type: measurement, video, reserved
// - Overflow indicator reports dropped frames
// - Value ends found only from continuation bits
// - Each video signal has own packet
// - At most one measurement packet per frame
// - Unused payload bits sent as zero
// - Change flag in every packet of frame
// - Overflow once per loss, repeated per frame
// - ASCII replies only after end-of-frame footer

module smpf_framer #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   irq,
  // Value stream from measuring logic
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [31:0]       in_value,
  input  wire logic [5:0]        in_width,
  input  wire smpf_pkg::smpf_dtype_t in_type,
  input  wire logic              in_pkt_last,
  input  wire logic              in_frame_last,
  // Events
  input  wire logic              cfg_change,
  input  wire logic              overflow,
  // UART transmit bytes
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic [7:0]             tx_data,
  // ASCII reply window
  output logic                   reply_allowed
);

  smpf_pkg::smpf_state_t state;
  smpf_pkg::smpf_state_t next_state;
  smpf_byte_if           eb ();

  logic                  ctrl_en;
  logic [3:0]            status;
  logic [3:0]            mask;
  logic                  hold_full;
  logic [31:0]           hold_value;
  logic [5:0]            hold_width;
  smpf_pkg::smpf_dtype_t hold_type;
  logic                  hold_pkt_last;
  logic                  hold_frame_last;
  smpf_pkg::smpf_dtype_t pkt_type;
  logic                  pkt_eof;
  logic                  tail_loaded;
  logic                  frame_open;
  logic                  meas_sent;
  logic                  tx_is_foot;
  logic                  tx_is_tail;
  logic                  enc_ready;
  logic [7:0]            foot_byte;
  logic                  pend_c;
  logic                  pend_o;

  // APB decode
  wire a_ctrl   = (paddr[7:0] == `SMPF_CTRL_OFF);
  wire a_stat   = (paddr[7:0] == `SMPF_STAT_OFF);
  wire a_mask   = (paddr[7:0] == `SMPF_MASK_OFF);
  wire a_info   = (paddr[7:0] == `SMPF_INFO_OFF);
  wire a_hit    = a_ctrl | a_stat | a_mask | a_info;
  wire setup    = psel & ~penable;
  wire wr_go    = psel & penable & pready & pwrite & a_hit;
  wire [31:0] info_word = {28'h0000000, frame_open, pend_o, pend_c, reply_allowed};
  wire [31:0] rd_word   = a_ctrl ? {31'h00000000, ctrl_en} :
                          a_stat ? {28'h0000000, status} :
                          a_mask ? {28'h0000000, mask} :
                          a_info ? info_word : 32'h0000_0000;

  // Input hold and packet decisions
  wire in_take   = in_valid & in_ready;
  wire is_idle   = (state == smpf_pkg::SMPF_IDLE);
  wire is_data   = (state == smpf_pkg::SMPF_DATA);
  wire is_foot   = (state == smpf_pkg::SMPF_FOOT);
  wire is_drop   = (state == smpf_pkg::SMPF_DROP);
  wire dup_meas  = (hold_type == `SMPF_DT_MEAS) & meas_sent;
  wire pkt_go    = is_idle & hold_full & ctrl_en & ~dup_meas & enc_ready;
  wire drop_go   = is_idle & hold_full & ctrl_en & dup_meas;
  wire data_load = is_data & hold_full & ~tail_loaded & enc_ready;
  wire enc_load  = pkt_go | data_load;
  wire drop_take = is_drop & hold_full;
  wire consume   = enc_load | drop_take;
  wire next_hold_full = (hold_full & ~consume) | in_take;
  wire capture   = pkt_go & ~frame_open;

  // Output stage
  wire out_free  = ~tx_valid | tx_ready;
  wire enc_take  = eb.valid & eb.ready;
  wire foot_go   = is_foot & out_free;
  wire frame_end = foot_go & pkt_eof;
  wire drop_end  = drop_take & hold_pkt_last;
  assign eb.ready = out_free & is_data;

  // Interrupt events
  wire [3:0] ev  = {drop_end, overflow, frame_end, foot_go};
  wire [3:0] w1c = (wr_go & a_stat) ? pwdata[3:0] : 4'h0;

  smpf_encoder u_enc (
    .clk        (clk),
    .rst        (rst),
    .load_valid (enc_load),
    .load_ready (enc_ready),
    .load_value (hold_value),
    .load_width (hold_width),
    .load_tail  (hold_pkt_last),
    .bo         (eb)
  );

  smpf_footer u_foot (
    .clk        (clk),
    .rst        (rst),
    .cfg_change (cfg_change),
    .overflow   (overflow),
    .capture    (capture),
    .frame_end  (frame_end),
    .dtype      (pkt_type),
    .eof        (pkt_eof),
    .foot_byte  (foot_byte),
    .pend_c     (pend_c),
    .pend_o     (pend_o)
  );

  // APB answer: data ready in the access cycle, no wait states
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~a_hit;
      prdata  <= setup ? rd_word : 32'h0000_0000;
    end
  end

  // Registers; a hardware set beats a write-one clear
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_en <= `SMPF_CTRL_RST;
      mask    <= `SMPF_MASK_RST;
      status  <= `SMPF_STAT_RST;
      irq     <= 1'b0;
    end else begin
      if (wr_go & a_ctrl) ctrl_en <= pwdata[0];
      if (wr_go & a_mask) mask <= pwdata[3:0];
      status  <= (status & ~w1c) | ev;
      irq     <= |(status & mask);
    end
  end

  // Hold register; in_ready mirrors its emptiness
  always_ff @(posedge clk) begin
    if (rst) begin
      hold_full       <= 1'b0;
      in_ready        <= 1'b0;
      hold_value      <= 32'h0000_0000;
      hold_width      <= `SMPF_MIN_WIDTH;
      hold_type       <= `SMPF_DT_MEAS;
      hold_pkt_last   <= 1'b0;
      hold_frame_last <= 1'b0;
    end else begin
      hold_full <= next_hold_full;
      in_ready  <= ~next_hold_full;
      if (in_take) begin
        hold_value      <= in_value;
        hold_width      <= in_width;
        hold_type       <= in_type;
        hold_pkt_last   <= in_pkt_last;
        hold_frame_last <= in_frame_last;
      end
    end
  end

  // Packet sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      smpf_pkg::SMPF_IDLE: begin
        if (pkt_go) next_state = smpf_pkg::SMPF_DATA;
        else if (drop_go) next_state = smpf_pkg::SMPF_DROP;
      end
      smpf_pkg::SMPF_DATA: begin
        if (enc_take & eb.tail) next_state = smpf_pkg::SMPF_FOOT;
      end
      smpf_pkg::SMPF_FOOT: begin
        if (out_free) next_state = smpf_pkg::SMPF_IDLE;
      end
      smpf_pkg::SMPF_DROP: begin
        if (drop_end) next_state = smpf_pkg::SMPF_IDLE;
      end
      default: next_state = smpf_pkg::SMPF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) state <= smpf_pkg::SMPF_IDLE;
    else state <= next_state;
  end

  // Packet and frame bookkeeping
  always_ff @(posedge clk) begin
    if (rst) begin
      pkt_type    <= `SMPF_DT_MEAS;
      pkt_eof     <= 1'b0;
      tail_loaded <= 1'b0;
      frame_open  <= 1'b0;
      meas_sent   <= 1'b0;
    end else begin
      if (pkt_go) begin
        pkt_type   <= hold_type;
        frame_open <= 1'b1;
        if (hold_type == `SMPF_DT_MEAS) meas_sent <= 1'b1;
      end
      if (enc_load & hold_pkt_last) begin
        tail_loaded <= 1'b1;
        pkt_eof     <= hold_frame_last;
      end else if (foot_go) begin
        tail_loaded <= 1'b0;
      end
      // A dropped closing packet still ends the frame
      if (frame_end | (drop_end & hold_frame_last)) begin
        frame_open <= 1'b0;
        meas_sent  <= 1'b0;
      end
    end
  end

  // Transmit register: held until accepted
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_valid   <= 1'b0;
      tx_data    <= 8'h00;
      tx_is_foot <= 1'b0;
      tx_is_tail <= 1'b0;
    end else if (out_free) begin
      tx_valid   <= enc_take | foot_go;
      tx_data    <= foot_go ? foot_byte : eb.data;
      tx_is_foot <= foot_go;
      tx_is_tail <= enc_take & eb.tail;
    end
  end

  // Reply window opens on an end-of-frame footer, shuts on next packet
  always_ff @(posedge clk) begin
    if (rst) reply_allowed <= 1'b0;
    else if (frame_end) reply_allowed <= 1'b1;
    else if (pkt_go) reply_allowed <= 1'b0;
  end

  // Checker state: a measurement footer already left in this frame
  logic meas_foot_seen;
  wire  foot_taken = tx_valid & tx_ready & tx_is_foot;
  wire  meas_foot  = foot_taken & (tx_data[`SMPF_FT_DT_HI:`SMPF_FT_DT_LO] == `SMPF_DT_MEAS);
  wire  frame_shut = (foot_taken & tx_data[`SMPF_FT_EOF]) | (drop_end & hold_frame_last);

  // Tracks frames from the wire side, not from the sequencer's own flag
  always_ff @(posedge clk) begin
    if (rst) meas_foot_seen <= 1'b0;
    else if (frame_shut) meas_foot_seen <= 1'b0;
    else if (meas_foot) meas_foot_seen <= 1'b1;
  end

  sequence tail_taken;
    tx_valid && tx_ready && tx_is_tail;
  endsequence

  sequence foot_shown;
    tx_valid && tx_is_foot;
  endsequence

  // Footer follows the last value byte directly
  foot_follow_a: assert property (@(posedge clk) disable iff (rst)
    tail_taken |=> foot_shown)
    else $error("footer did not follow final value byte");

  // Footer never looks like a prompt
  foot_prompt_a: assert property (@(posedge clk) disable iff (rst)
    foot_shown |-> (tx_data[`SMPF_FT_PROMPT] == 1'b0))
    else $error("footer bit 5 set");

  // Footer top bits clear
  foot_top_a: assert property (@(posedge clk) disable iff (rst)
    foot_shown |-> (tx_data[7] == 1'b0 && tx_data[`SMPF_FT_EXTRA] == 1'b0))
    else $error("footer bit 7 or 6 set");

  // Final byte of a packet's last value has the continuation bit clear
  cont_bit_a: assert property (@(posedge clk) disable iff (rst)
    (tx_valid && !tx_is_foot && tx_is_tail) |-> (tx_data[7] == 1'b0))
    else $error("continuation bit wrong");

  // A set continuation bit is followed by another value byte
  cont_next_a: assert property (@(posedge clk) disable iff (rst)
    (tx_valid && tx_ready && !tx_is_foot && tx_data[7]) |=> (tx_valid && !tx_is_foot))
    else $error("value byte missing after continuation");

  // Byte held steady while stalled
  byte_hold_a: assert property (@(posedge clk) disable iff (rst)
    (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data)))
    else $error("byte changed before acceptance");

  // Reply window opens only with an end-of-frame footer
  reply_open_a: assert property (@(posedge clk) disable iff (rst)
    $rose(reply_allowed) |-> (foot_shown and (tx_data[`SMPF_FT_EOF] == 1'b1)))
    else $error("reply window opened without end of frame");

  // No second measurement packet in one frame
  meas_once_a: assert property (@(posedge clk) disable iff (rst)
    (pkt_go && hold_type == `SMPF_DT_MEAS) |-> !meas_sent)
    else $error("second measurement packet in frame");

  // At most one measurement footer leaves per frame
  meas_foot_once_a: assert property (@(posedge clk) disable iff (rst)
    meas_foot |-> !meas_foot_seen)
    else $error("second measurement footer in frame");

  // Footer type matches the packet
  foot_type_a: assert property (@(posedge clk) disable iff (rst)
    foot_shown |-> (tx_data[`SMPF_FT_DT_HI:`SMPF_FT_DT_LO] == $past(pkt_type)))
    else $error("footer payload type mismatch");

  // Interrupt follows masked status one cycle later
  irq_level_a: assert property (@(posedge clk) disable iff (rst)
    ##1 (irq == |($past(status) & $past(mask))))
    else $error("interrupt level wrong");

endmodule

// >>> verilog/smpf_map.svh
`ifndef SMPF_MAP_SVH
`define SMPF_MAP_SVH

// Register byte offsets
`define SMPF_CTRL_OFF   8'h00
`define SMPF_STAT_OFF   8'h04
`define SMPF_MASK_OFF   8'h08
`define SMPF_INFO_OFF   8'h0C

// Reset values
`define SMPF_CTRL_RST   1'h0
`define SMPF_STAT_RST   4'h0
`define SMPF_MASK_RST   4'h0

// Status and mask bit positions
`define SMPF_ST_PKT     0
`define SMPF_ST_FRAME   1
`define SMPF_ST_OVF     2
`define SMPF_ST_DUP     3

// Footer bit positions
`define SMPF_FT_EXTRA   6
`define SMPF_FT_PROMPT  5
`define SMPF_FT_EOF     4
`define SMPF_FT_CHG     3
`define SMPF_FT_DT_HI   2
`define SMPF_FT_DT_LO   1
`define SMPF_FT_OVF     0

// Value coding
`define SMPF_GRP_BITS   7
`define SMPF_MIN_WIDTH  6'h0E
`define SMPF_MAX_WIDTH  6'h20
`define SMPF_W_3BYTES   6'h15
`define SMPF_W_4BYTES   6'h1C

// Payload type codes
`define SMPF_DT_MEAS    2'h0
`define SMPF_DT_VIDEO   2'h1

`endif

// >>> verilog/smpf_pkg.sv
package smpf_pkg;

  // Packet sequencer states
  typedef enum logic [1:0] {
    SMPF_IDLE = 2'b00,
    SMPF_DATA = 2'b01,
    SMPF_FOOT = 2'b10,
    SMPF_DROP = 2'b11
  } smpf_state_t;

  // Payload type field
  typedef logic [1:0] smpf_dtype_t;

endpackage
